// ==== src/ccss_pkg.sv ====
// Constants for the CPU clock source switcher
package ccss_pkg;
  localparam int             CCSS_AW           = 8;
  // Register byte offsets
  localparam logic [7:0]     CCSS_OFS_MODE     = 8'h00;
  localparam logic [7:0]     CCSS_OFS_SET_SEL  = 8'h04;
  localparam logic [7:0]     CCSS_OFS_RUN      = 8'h08;
  localparam logic [7:0]     CCSS_OFS_SET_STAT = 8'h0c;
  localparam logic [7:0]     CCSS_OFS_SYSCLK   = 8'h10;
  // Field positions
  localparam int             CCSS_BIT_EXT_IN   = 7;
  localparam int             CCSS_BIT_XTAL     = 6;
  localparam int             CCSS_BIT_GAIN_HI  = 0;
  localparam int             CCSS_BIT_MAIN_HLT = 7;
  localparam int             CCSS_BIT_FAST_HLT = 0;
  localparam int             CCSS_BIT_SRC_STAT = 5;
  localparam int             CCSS_BIT_SRC_SEL  = 4;
  localparam int             CCSS_SEL_W        = 3;
  // Reset values
  localparam logic [7:0]     CCSS_RST_MODE     = 8'h00;
  localparam logic [2:0]     CCSS_RST_SET_SEL  = 3'h7;
  localparam logic [7:0]     CCSS_RST_RUN      = 8'h80;
  // Settle counter: thresholds in crystal periods, 2^8 .. 2^18
  localparam int             CCSS_CNT_W        = 19;
  localparam logic [18:0]    CCSS_THR [8]      = '{
    19'h0_0100, 19'h0_0200, 19'h0_0400, 19'h0_0800,
    19'h0_2000, 19'h0_8000, 19'h2_0000, 19'h4_0000};
  // Source switch: periods of old, then new source
  localparam logic [2:0]     CCSS_SW_OLD_TICKS = 3'h2;
  localparam logic [2:0]     CCSS_SW_NEW_TICKS = 3'h2;
endpackage : ccss_pkg

// ==== src/ccss_if.sv ====
// Internal links between the top and its settle and switch units
interface ccss_if;
  import ccss_pkg::*;
  logic                  mx_run;
  logic                  mx_tick;
  logic                  fast_tick;
  logic [CCSS_SEL_W-1:0] set_sel;
  logic [7:0]            elapsed;
  logic                  settle_done;
  logic                  src_req;
  logic                  src_stat;
  logic                  sw_busy;
  modport top    (output mx_run, mx_tick, fast_tick, set_sel, src_req,
                  input  elapsed, settle_done, src_stat, sw_busy);
  modport settle (input  mx_run, mx_tick, set_sel,
                  output elapsed, settle_done);
  modport sw     (input  mx_tick, fast_tick, src_req,
                  output src_stat, sw_busy);
endinterface : ccss_if

// ==== src/ccss_settle.sv ====
// Oscillation settle counter with thermometer status
module ccss_settle
  import ccss_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  ccss_if.settle    lk
);
  logic [CCSS_CNT_W-1:0] cnt_q;

  // Counts crystal periods; restarts whenever the oscillator is stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (!lk.mx_run) begin
      cnt_q <= '0;
    end else if (lk.mx_tick && cnt_q < CCSS_THR[7]) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Bit 7 is the shortest time, bit 0 the longest
  genvar i;
  for (i = 0; i < 8; i++) begin : g_therm
    assign lk.elapsed[7-i] = (cnt_q >= CCSS_THR[i]); // [R6]
  end

  assign lk.settle_done = (cnt_q >= CCSS_THR[lk.set_sel]); // [R4]
endmodule : ccss_settle

// ==== src/ccss_switch.sv ====
// Glitch-free main clock source changeover sequencer
module ccss_switch
  import ccss_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  ccss_if.sw        lk
);
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OLD  = 3'b010,
    SW_NEW  = 3'b100
  } ccss_sw_t;

  ccss_sw_t   st_q;
  logic [2:0] cnt_q;
  logic       tgt_q;
  logic       stat_q;
  logic       old_tick;
  logic       new_tick;

  assign old_tick = stat_q ? lk.mx_tick : lk.fast_tick;
  assign new_tick = tgt_q ? lk.mx_tick : lk.fast_tick;

  // Old source finishes its periods, then new one must prove it runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= SW_IDLE;
      cnt_q  <= '0;
      tgt_q  <= 1'b0;
      stat_q <= 1'b0;
    end else begin
      case (st_q)
        SW_IDLE: begin
          cnt_q <= '0;
          if (lk.src_req != stat_q) begin
            tgt_q <= lk.src_req;
            st_q  <= SW_OLD;
          end
        end
        SW_OLD: begin
          if (old_tick) begin
            if (cnt_q == CCSS_SW_OLD_TICKS - 3'h1) begin
              cnt_q <= '0;
              st_q  <= SW_NEW;
            end else begin
              cnt_q <= cnt_q + 3'h1;
            end
          end
        end
        SW_NEW: begin
          if (new_tick) begin
            if (cnt_q == CCSS_SW_NEW_TICKS - 3'h1) begin
              stat_q <= tgt_q; // [R16] [R17]
              st_q   <= SW_IDLE;
            end else begin
              cnt_q <= cnt_q + 3'h1;
            end
          end
        end
        default: st_q <= SW_IDLE;
      endcase
    end
  end

  assign lk.src_stat = stat_q;
  assign lk.sw_busy  = (st_q != SW_IDLE);
endmodule : ccss_switch

// ==== src/ccss_top.sv ====
// CPU clock source switcher: registers, standby control, clock select
//
// Functional notes
// R1 - Software programs mode, settle, start, poll, select
// R2 - Mode select bit puts crystal pins oscillating
// R3 - Above 10 MHz software sets gain high
// R4 - Settle select field sets wake-up wait
// R5 - Main halt bit clear starts crystal oscillator
// R6 - Elapsed status is thermometer; poll before switching
// R7 - Source select bit picks high-speed system clock
// R8 - Mode register accepts only first write
// R9 - Polled time must not exceed selected time
// R10 - External clock: set both mode bits, start
// R11 - Return: start fast oscillator, wait, deselect
// R12 - Reset: fast oscillator runs, crystal pins idle
// R13 - Halt stops CPU clock, oscillator keeps running
// R14 - Stop halts both oscillators
// R15 - Software quiesces peripherals, programs settle before stop
// R16 - Status bit shows active source after delay
// R17 - Switch glitch-free; status follows actual source
module ccss_top
  import ccss_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [CCSS_AW-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               crystal_tick,
  input  wire logic               fast_osc_tick,
  input  wire logic               halt_exec,
  input  wire logic               stop_exec,
  input  wire logic               wake_event,
  output logic                    cpu_clk_en,
  output logic                    periph_clk_en,
  output logic                    fast_osc_en,
  output logic                    main_osc_en,
  output logic                    crystal_osc_mode,
  output logic                    ext_clk_in_en,
  output logic                    osc_gain_high,
  output logic                    main_clk_from_mx
);
  typedef enum logic [3:0] {
    PM_RUN  = 4'b0001,
    PM_HALT = 4'b0010,
    PM_STOP = 4'b0100,
    PM_WAKE = 4'b1000
  } ccss_pm_t;

  ccss_if lk ();

  logic [7:0]            mode_q;
  logic                  mode_done_q;
  logic [CCSS_SEL_W-1:0] set_sel_q;
  logic                  main_halt_q;
  logic                  fast_halt_q;
  logic                  src_sel_q;
  ccss_pm_t              pm_q;
  logic                  dp_wr_q;
  logic [CCSS_AW-1:0]    dp_addr_q;
  logic [31:0]           rdata_q;
  logic [7:0]            rd_d;
  logic                  ap_take;
  logic                  wr_en;
  logic                  crystal_pins;
  logic                  ext_in;
  logic                  in_stop;

  ccss_settle u_settle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lk      (lk.settle)
  );

  ccss_switch u_switch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lk      (lk.sw)
  );

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign ap_take   = hsel && hready && htrans[1];
  assign wr_en     = dp_wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
    end else begin
      dp_wr_q <= ap_take && hwrite;
      if (ap_take) begin
        dp_addr_q <= haddr;
      end
    end
  end

  // Read data is built in the address phase, so it stands in the data phase
  always_comb begin
    rd_d = 8'h00;
    case (haddr)
      CCSS_OFS_MODE:     rd_d = mode_q;
      CCSS_OFS_SET_SEL:  rd_d = {{(8-CCSS_SEL_W){1'b0}}, set_sel_q};
      CCSS_OFS_RUN: begin
        rd_d[CCSS_BIT_MAIN_HLT] = main_halt_q;
        rd_d[CCSS_BIT_FAST_HLT] = fast_halt_q;
      end
      CCSS_OFS_SET_STAT: rd_d = lk.elapsed; // [R6]
      CCSS_OFS_SYSCLK: begin
        rd_d[CCSS_BIT_SRC_STAT] = lk.src_stat; // [R16]
        rd_d[CCSS_BIT_SRC_SEL]  = src_sel_q;
      end
      default:           rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (ap_take && !hwrite) begin
      rdata_q <= {24'h00_0000, rd_d};
    end
  end

  // Mode register locks after its first write since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q      <= CCSS_RST_MODE; // [R12]
      mode_done_q <= 1'b0;
    end else if (wr_en && dp_addr_q == CCSS_OFS_MODE && !mode_done_q) begin
      mode_q      <= hwdata[7:0]; // [R8]
      mode_done_q <= 1'b1; // [R8]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_sel_q <= CCSS_RST_SET_SEL;
    end else if (wr_en && dp_addr_q == CCSS_OFS_SET_SEL) begin
      set_sel_q <= hwdata[CCSS_SEL_W-1:0]; // [R4]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_halt_q <= CCSS_RST_RUN[CCSS_BIT_MAIN_HLT]; // [R12]
      fast_halt_q <= CCSS_RST_RUN[CCSS_BIT_FAST_HLT]; // [R12]
    end else if (wr_en && dp_addr_q == CCSS_OFS_RUN) begin
      main_halt_q <= hwdata[CCSS_BIT_MAIN_HLT]; // [R5]
      fast_halt_q <= hwdata[CCSS_BIT_FAST_HLT]; // [R5]
    end
  end

  // Status bit is read-only; only the select bit takes writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_sel_q <= 1'b0; // [R12]
    end else if (wr_en && dp_addr_q == CCSS_OFS_SYSCLK) begin
      src_sel_q <= hwdata[CCSS_BIT_SRC_SEL]; // [R7]
    end
  end

  // Standby: halt gates the CPU only, stop kills both oscillators.
  // Wake from stop on the crystal waits out the selected settle time.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pm_q <= PM_RUN;
    end else begin
      case (pm_q)
        PM_RUN: begin
          if (stop_exec) begin
            pm_q <= PM_STOP; // [R14]
          end else if (halt_exec) begin
            pm_q <= PM_HALT; // [R13]
          end
        end
        PM_HALT: begin
          if (wake_event) begin
            pm_q <= PM_RUN;
          end
        end
        PM_STOP: begin
          if (wake_event) begin
            pm_q <= (lk.src_stat && !ext_in) ? PM_WAKE : PM_RUN; // [R4]
          end
        end
        PM_WAKE: begin
          if (lk.settle_done) begin
            pm_q <= PM_RUN; // [R4]
          end
        end
        default: pm_q <= PM_RUN;
      endcase
    end
  end

  assign in_stop      = (pm_q == PM_STOP);
  assign crystal_pins = mode_q[CCSS_BIT_XTAL]; // [R2]
  assign ext_in       = mode_q[CCSS_BIT_EXT_IN];

  // Crystal pins stay plain inputs until the mode bit is set
  assign crystal_osc_mode = crystal_pins && !ext_in; // [R2] [R12]
  assign ext_clk_in_en    = crystal_pins && ext_in;
  // Gain only matters for a resonator; ignored with external input
  assign osc_gain_high    = crystal_osc_mode && mode_q[CCSS_BIT_GAIN_HI];
  assign main_osc_en      = crystal_pins && !main_halt_q && !in_stop; // [R5] [R14]
  // Halt leaves the running oscillator alone
  assign fast_osc_en      = !fast_halt_q && !in_stop; // [R13] [R14]
  assign cpu_clk_en       = (pm_q == PM_RUN); // [R13]
  assign periph_clk_en    = (pm_q == PM_RUN) || (pm_q == PM_HALT);
  assign main_clk_from_mx = lk.src_stat; // [R17]

  // Ticks only count while the owning oscillator is enabled
  assign lk.mx_run    = main_osc_en;
  assign lk.mx_tick   = crystal_tick && main_osc_en;
  assign lk.fast_tick = fast_osc_tick && fast_osc_en;
  assign lk.set_sel   = set_sel_q;
  assign lk.src_req   = src_sel_q; // [R7]

  // Word-only bus; transfer size carries no meaning here
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0], hwdata[31:8], lk.sw_busy};
endmodule : ccss_top

// ==== tb/ccss_osc_model.sv ====
// Oscillator stand-in: a tick every PER cycles while enabled
module ccss_osc_model #(
  parameter int PER = 2
) (
  input  wire logic clk,
  input  wire logic en,
  output logic      tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Stands still while disabled, like a stopped resonator
  always @(posedge clk) begin
    if (en !== 1'b1) begin
      cnt  <= 0;
      tick <= 1'b0;
    end else begin
      cnt  <= (cnt == PER - 1) ? 0 : cnt + 1;
      tick <= (cnt == PER - 1);
    end
  end
endmodule : ccss_osc_model

// ==== tb/ccss_top_sva.sv ====
// Port-level assertions for the clock source switcher
module ccss_chk
  import ccss_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [CCSS_AW-1:0] haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               halt_exec,
  input wire logic               stop_exec,
  input wire logic               wake_event,
  input wire logic               cpu_clk_en,
  input wire logic               periph_clk_en,
  input wire logic               fast_osc_en,
  input wire logic               main_osc_en,
  input wire logic               crystal_osc_mode,
  input wire logic               ext_clk_in_en,
  input wire logic               osc_gain_high,
  input wire logic               main_clk_from_mx
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic               wr_q;
  logic               sel_q;
  logic               lock_q;
  logic               lock2_q;
  logic [CCSS_AW-1:0] wa_q;
  // Bus shadow; lock2 skips the edge at which the mode write lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      wa_q    <= '0;
      sel_q   <= 1'b0;
      lock_q  <= 1'b0;
      lock2_q <= 1'b0;
    end else begin
      wr_q    <= hsel && hready && htrans[1] && hwrite;
      wa_q    <= haddr;
      lock2_q <= lock_q;
      if (wr_q && wa_q == CCSS_OFS_SYSCLK)
        sel_q <= hwdata[CCSS_BIT_SRC_SEL];
      if (wr_q && wa_q == CCSS_OFS_MODE)
        lock_q <= 1'b1;
    end
  end
  chk_reset_idle: assert property (
    $rose(hresetn) |-> cpu_clk_en && fast_osc_en && !main_osc_en
      && !crystal_osc_mode && !ext_clk_in_en && !main_clk_from_mx)
    else $error("outputs not idle after reset");
  chk_halt_cpu: assert property (
    halt_exec && !stop_exec && cpu_clk_en |=> !cpu_clk_en && periph_clk_en)
    else $error("halt did not stop only the cpu clock");
  chk_halt_osc: assert property (
    halt_exec && !stop_exec && cpu_clk_en
      |=> $stable(fast_osc_en) && $stable(main_osc_en))
    else $error("halt changed an oscillator");
  chk_stop_all: assert property (
    stop_exec && cpu_clk_en
      |=> !(fast_osc_en || main_osc_en || cpu_clk_en || periph_clk_en))
    else $error("stop left a clock running");
  chk_wake_settle: assert property (
    wake_event && !periph_clk_en && main_clk_from_mx && !ext_clk_in_en
      |=> (main_osc_en && !cpu_clk_en) [*8])
    else $error("wake skipped the settle wait");
  chk_mode_lock: assert property (
    lock2_q |-> $stable(crystal_osc_mode)
      && $stable(ext_clk_in_en) && $stable(osc_gain_high))
    else $error("mode changed after its first write");
  chk_gain_ext: assert property (
    osc_gain_high |-> !ext_clk_in_en)
    else $error("gain high with external input");
  chk_switch_slow: assert property (
    $changed(sel_q) && sel_q != main_clk_from_mx
      |=> $stable(main_clk_from_mx) [*3])
    else $error("source status moved too soon");
  chk_status_dir: assert property (
    $changed(main_clk_from_mx) |-> main_clk_from_mx == sel_q)
    else $error("status moved away from select");
endmodule : ccss_chk

bind ccss_top ccss_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .halt_exec, .stop_exec, .wake_event,
  .cpu_clk_en, .periph_clk_en, .fast_osc_en, .main_osc_en,
  .crystal_osc_mode, .ext_clk_in_en, .osc_gain_high, .main_clk_from_mx);

// ==== tb/testbench.sv ====
// Self-checking bench for the clock source switcher
module testbench
  import ccss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] v; logic [7:0] m;} ccss_exp_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr, r;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd_v;
  logic        xt, ft, halt_exec, stop_exec, wake_event, rd_ph, mx;
  logic        cpu_clk_en, periph_clk_en, fast_osc_en, main_osc_en;
  logic        crystal_osc_mode, ext_clk_in_en, osc_gain_high;
  ccss_exp_t   exp_q[$];
  ccss_exp_t   e;
  int          error_cnt, n_tests, seed, n;
  assign hready = hreadyout;
  ccss_osc_model #(.PER(2)) xtal_u (.clk(hclk), .en(main_osc_en), .tick(xt));
  ccss_osc_model #(.PER(3)) fosc_u (.clk(hclk), .en(fast_osc_en), .tick(ft));
  ccss_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .crystal_tick(xt), .fast_osc_tick(ft), .halt_exec, .stop_exec,
    .wake_event, .cpu_clk_en, .periph_clk_en, .fast_osc_en, .main_osc_en,
    .crystal_osc_mode, .ext_clk_in_en, .osc_gain_high,
    .main_clk_from_mx(mx));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic edge_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 16) begin
        error_cnt++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask : edge_rdy
  // Reads note their expectation; mask zero means value is only polled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic [7:0] m);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    if (!w) exp_q.push_back('{d, m});
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    edge_rdy();
    rd_v = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 8'hff);
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    bus(1'b0, a, 8'h00, 8'h00);
    while (rd_v[7:0] !== v) begin
      k++;
      if (k > 1500) begin
        error_cnt++;
        give_verdict();
      end
      bus(1'b0, a, 8'h00, 8'h00);
    end
  endtask : poll
  task automatic fire(input logic [2:0] p);
    {stop_exec, halt_exec, wake_event} <= p;
    @(posedge hclk);
    {stop_exec, halt_exec, wake_event} <= 3'h0;
    @(posedge hclk);
  endtask : fire
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      e = exp_q.pop_front();
      if (e.m != 8'h00) begin
        check(hrdata, {24'h00_0000, e.v & e.m});
      end
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    {hsel, hwrite, stop_exec, halt_exec, wake_event} = 5'h00;
    {htrans, haddr, hwdata} = '0;
    {error_cnt, n_tests, seed} = {32'h0, 32'h0, 32'h12};
    hresetn = 1'b1;
    do_reset();
    check({27'h0, cpu_clk_en, fast_osc_en, main_osc_en, mx, hresp}, 32'h18);
    rd(CCSS_OFS_MODE, 8'h00);
    rd(CCSS_OFS_SET_SEL, 8'h07);
    rd(CCSS_OFS_RUN, 8'h80);
    wr(CCSS_OFS_SET_STAT, 8'hff);
    rd(CCSS_OFS_SET_STAT, 8'h00);
    wr(CCSS_OFS_SYSCLK, 8'h20);
    rd(CCSS_OFS_SYSCLK, 8'h00);
    rd(8'h14, 8'h00);
    repeat (4) begin
      r = 8'($random(seed));
      wr(CCSS_OFS_SET_SEL, r);
      rd(CCSS_OFS_SET_SEL, {5'h00, r[2:0]});
    end
    // Standby on the fast oscillator: no settle wait on wake
    fire(3'h2);
    check({30'h0, cpu_clk_en, fast_osc_en}, 32'h1);
    fire(3'h1);
    fire(3'h4);
    check({31'h0, fast_osc_en}, 32'h0);
    fire(3'h1);
    check({31'h0, cpu_clk_en}, 32'h1);
    wr(CCSS_OFS_MODE, 8'h41);
    wr(CCSS_OFS_SET_SEL, 8'h02);
    wr(CCSS_OFS_MODE, 8'h80);
    rd(CCSS_OFS_MODE, 8'h41);
    wr(CCSS_OFS_RUN, 8'h00);
    @(posedge hclk);
    check({29'h0, main_osc_en, crystal_osc_mode, osc_gain_high}, 32'h7);
    poll(CCSS_OFS_SET_STAT, 8'he0);
    wr(CCSS_OFS_SYSCLK, 8'h10);
    poll(CCSS_OFS_SYSCLK, 8'h30);
    wr(CCSS_OFS_RUN, 8'h01);
    @(posedge hclk);
    check({30'h0, fast_osc_en, main_osc_en}, 32'h1);
    fire(3'h2);
    check({29'h0, cpu_clk_en, periph_clk_en, main_osc_en}, 32'h3);
    fire(3'h1);
    check({31'h0, cpu_clk_en}, 32'h1);
    fire(3'h4);
    check({28'h0, cpu_clk_en, periph_clk_en, main_osc_en, fast_osc_en}, 32'h0);
    repeat (20) @(posedge hclk);
    fire(3'h1);
    // Settle code 2 is 2^10 crystal ticks, one tick every 2 cycles;
    // a few cycles of start-up, far below the next threshold
    n = 2;
    while (cpu_clk_en !== 1'b1 && n < 5000) begin
      n++;
      @(posedge hclk);
    end
    check({31'h0, n >= 2048 && n <= 2064}, 32'h1);
    if (n >= 5000) give_verdict();
    wr(CCSS_OFS_RUN, 8'h00);
    repeat (3375) @(posedge hclk);
    wr(CCSS_OFS_SYSCLK, 8'h00);
    poll(CCSS_OFS_SYSCLK, 8'h00);
    do_reset();
    check({27'h0, cpu_clk_en, fast_osc_en, main_osc_en, mx, hresp}, 32'h18);
    wr(CCSS_OFS_MODE, 8'hc1);
    wr(CCSS_OFS_RUN, 8'h00);
    @(posedge hclk);
    check({30'h0, ext_clk_in_en, osc_gain_high}, 32'h2);
    wr(CCSS_OFS_SYSCLK, 8'h10);
    poll(CCSS_OFS_SYSCLK, 8'h30);
    // External input needs no settle wait on wake from stop
    fire(3'h4);
    check({30'h0, main_osc_en, cpu_clk_en}, 32'h0);
    fire(3'h1);
    check({31'h0, cpu_clk_en}, 32'h1);
    give_verdict();
  end
endmodule : testbench
